// ==== core/cpmrc_pkg.sv ====
package cpmrc_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PLL_CTRL = 4'h1;
    localparam logic [3:0] ADDR_PLL_STAT = 4'h2;
    localparam logic [3:0] ADDR_LSO_CTRL = 4'h3;
    localparam logic [3:0] ADDR_WAKE_CTRL = 4'h4;
    localparam logic [3:0] ADDR_WAKE_CNT = 4'h5;
    localparam logic [3:0] ADDR_TEMPLATE = 4'h6;
    localparam logic [3:0] ADDR_MODE = 4'h7;
    localparam logic [3:0] ADDR_RESET = 4'h8;
    localparam logic [3:0] ADDR_WDOG = 4'h9;

    // ----------------------------------------
    // field positions and codes
    // ----------------------------------------
    localparam int OSC_DBL_EN_BIT = 3;
    localparam int OSC_DBL_SRC_BIT = 4;
    localparam int PLL_EN_BIT = 0;
    localparam int PLL_CLR_RST_BIT = 0;
    localparam int WAKE_EN_BIT = 0;
    localparam int WAKE_IRQ_BIT = 1;
    localparam int WAKE_CLR_BIT = 2;
    localparam int RST_SW_BIT = 0;
    localparam int CPU_TEMPLATE_BIT = 0;
    localparam logic [2:0] IMO_3M = 3'h0;
    localparam logic [2:0] IMO_48M = 3'h4;
    localparam logic [15:0] WDOG_KEY = 16'hA5A5;

    localparam logic [2:0] RST_SRC_NONE = 3'h0;
    localparam logic [2:0] RST_SRC_EXT = 3'h1;
    localparam logic [2:0] RST_SRC_WDOG = 3'h2;
    localparam logic [2:0] RST_SRC_SW = 3'h3;
    localparam logic [2:0] RST_SRC_POWER = 3'h4;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] TEMPLATE_RST = 8'hFF;
    localparam logic [3:0] PLL_IN_DIV_RST = 4'h0;
    localparam logic [5:0] PLL_FB_DIV_RST = 6'h0F;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int PLL_LOCK_US = 250;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_US * (CLK_HZ / 1000000) > 0) ?
        PLL_LOCK_US * (CLK_HZ / 1000000) : 1;
    localparam int WAKE_TIME_US = 125;
    localparam int WAKE_TIME_CYC = WAKE_TIME_US * (CLK_HZ / 1000000);
    localparam int RST_PULSE_CYC = 4;

    typedef enum logic [3:0] {
        CPMRC_ACTIVE = 4'b0001,
        CPMRC_ALT_ACTIVE = 4'b0010,
        CPMRC_SLEEP = 4'b0100,
        CPMRC_HIBERNATE = 4'b1000
    } cpmrc_mode_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cpmrc_bus_s;

    typedef struct packed {
        logic [2:0] imo_sel;
        logic dbl_en;
        logic dbl_src;
        logic pll_en;
        logic [1:0] pll_src;
        logic [3:0] pll_in_div;
        logic [5:0] pll_fb_div;
        logic [1:0] slow_sel;
    } cpmrc_clk_s;

endpackage

// ==== core/cpmrc_top.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - main oscillator selects 3,6,12,24,48 MHz
// - doubler x2, source crystal or interconnect
// - pll 24-67 MHz, input/feedback dividers
// - pll reference: main, crystal, interconnect
// - pll locks within 250 us, status bit
// - lock also driven out as routable signal
// - low-speed osc gives 1k, 33k, 100k
// - 100k as cpu clock, fast interval counter
// - wake counter free-runs on 1k ticks
// - wake counter stops in hibernate, debug halt
// - firmware may clear wake counter anytime
// - periodic wake events, optional interrupt request
// - active template bits gate subsystem clocks
// - cpu may stop itself, re-enabled on wake
// - wake returns active mode, cpu enabled
// - active mode after boot
// - sleep: cpu off, counter runs, wake 125us
// - hibernate keeps state, leaves on external reset
// - external reset pin low holds reset
// - watchdog resets if unserviced, active only
// - software-triggered reset available
module cpmrc_top #(
    parameter logic [31:0] WDOG_TIMEOUT = 32'd100000,
    parameter logic [15:0] WAKE_INTERVAL = 16'd1000,
    parameter int PLL_LOCK_CYCLES = cpmrc_pkg::PLL_LOCK_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire cpmrc_pkg::cpmrc_bus_s i_bus,
    input wire logic i_ext_reset_n,
    input wire logic i_slow_tick_1k,
    input wire logic i_power_fault,
    input wire logic i_debug_halt,
    output logic [31:0] o_rdata,
    output cpmrc_pkg::cpmrc_clk_s o_clk_cfg,
    output logic o_pll_lock,
    output logic [7:0] o_clk_gate_en,
    output logic o_cpu_en,
    output logic [3:0] o_mode,
    output logic o_wake_event,
    output logic o_wake_irq,
    output logic o_sys_reset
);
    import cpmrc_pkg::*;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // tick edge needs a third flop, read only past the sync pair
    logic [1:0] ext_sync_reg;
    logic [2:0] tick_sync_reg;
    logic [1:0] dbg_sync_reg;
    logic [1:0] pf_sync_reg;
    logic ext_rst;
    logic tick_1k;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_sync_reg <= 2'h3;
            tick_sync_reg <= 3'h0;
            dbg_sync_reg <= 2'h0;
            pf_sync_reg <= 2'h0;
        end else begin
            ext_sync_reg <= {ext_sync_reg[0], i_ext_reset_n};
            tick_sync_reg <= {tick_sync_reg[1:0], i_slow_tick_1k};
            dbg_sync_reg <= {dbg_sync_reg[0], i_debug_halt};
            pf_sync_reg <= {pf_sync_reg[0], i_power_fault};
        end
    end

    assign ext_rst = !ext_sync_reg[1];
    assign tick_1k = tick_sync_reg[1] && !tick_sync_reg[2];

    // ----------------------------------------
    // clock configuration
    // ----------------------------------------
    cpmrc_clk_s clk_reg;
    cpmrc_mode_e mode_reg;
    logic [7:0] template_reg;
    logic cpu_off_reg;
    logic [1:0] wake_ctrl_reg;
    logic [15:0] wake_cnt_reg;
    logic [15:0] wake_acc_reg;
    logic wake_reg;
    logic wake_irq_reg;
    logic [31:0] wdog_reg;
    logic wdog_fire;
    logic sw_fire;
    logic [2:0] rst_src_reg;
    logic [2:0] rst_cnt_reg;
    logic [31:0] pll_cnt_reg;
    logic lock_reg;
    logic [31:0] rdata_reg;
    logic wake_pending_reg;
    logic [31:0] wake_dly_reg;


    // one decode shared by every register write
    function automatic logic wr_hit(input cpmrc_bus_s b, input logic [3:0] a);
        return b.wr && (b.addr == a);
    endfunction

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            clk_reg <= '0;
            clk_reg.pll_in_div <= PLL_IN_DIV_RST;
            clk_reg.pll_fb_div <= PLL_FB_DIV_RST;
        end else if (wr_hit(i_bus, ADDR_OSC_CTRL)) begin
            // codes above 48 MHz clamp, only five outputs exist
            clk_reg.imo_sel <= (i_bus.wdata[2:0] > IMO_48M) ? IMO_48M
                               : i_bus.wdata[2:0];
            clk_reg.dbl_en <= i_bus.wdata[OSC_DBL_EN_BIT];
            clk_reg.dbl_src <= i_bus.wdata[OSC_DBL_SRC_BIT];
            clk_reg.slow_sel <= i_bus.wdata[6:5];
        end else if (wr_hit(i_bus, ADDR_PLL_CTRL)) begin
            clk_reg.pll_en <= i_bus.wdata[PLL_EN_BIT];
            // source code 3 is unused; it falls back to the main oscillator
            clk_reg.pll_src <= (i_bus.wdata[2:1] == 2'h3) ? 2'h0
                               : i_bus.wdata[2:1];
            clk_reg.pll_in_div <= i_bus.wdata[7:4];
            clk_reg.pll_fb_div <= i_bus.wdata[13:8];
        end
    end

    // ----------------------------------------
    // pll lock timer
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pll_cnt_reg <= 32'h0;
            lock_reg <= 1'b0;
        end else if (!clk_reg.pll_en || wr_hit(i_bus, ADDR_PLL_CTRL)) begin
            // any reprogramming restarts the lock wait
            pll_cnt_reg <= 32'h0;
            lock_reg <= 1'b0;
        end else if (pll_cnt_reg >= 32'(PLL_LOCK_CYCLES - 1)) begin
            lock_reg <= 1'b1;
        end else begin
            pll_cnt_reg <= pll_cnt_reg + 32'h1;
        end
    end

    // ----------------------------------------
    // wake counter
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wake_ctrl_reg <= 2'h0;
        end else if (wr_hit(i_bus, ADDR_WAKE_CTRL)) begin
            wake_ctrl_reg <= {i_bus.wdata[WAKE_IRQ_BIT], i_bus.wdata[WAKE_EN_BIT]};
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wake_cnt_reg <= 16'h0;
            wake_acc_reg <= 16'h0;
            wake_reg <= 1'b0;
            wake_irq_reg <= 1'b0;
        end else begin
            wake_reg <= 1'b0;
            wake_irq_reg <= 1'b0;
            // a clear beats a tick landing in the same cycle
            if (wr_hit(i_bus, ADDR_WAKE_CTRL) && i_bus.wdata[WAKE_CLR_BIT]) begin
                wake_cnt_reg <= 16'h0;
                wake_acc_reg <= 16'h0;
            end else if (tick_1k && mode_reg != CPMRC_HIBERNATE
                         && !dbg_sync_reg[1]) begin
                wake_cnt_reg <= wake_cnt_reg + 16'h1;
                if (wake_acc_reg >= WAKE_INTERVAL - 16'h1) begin
                    wake_acc_reg <= 16'h0;
                    wake_reg <= wake_ctrl_reg[0];
                    wake_irq_reg <= wake_ctrl_reg[0] && wake_ctrl_reg[1];
                end else begin
                    wake_acc_reg <= wake_acc_reg + 16'h1;
                end
            end
        end
    end

    // ----------------------------------------
    // power modes
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_reg <= CPMRC_ACTIVE;
            template_reg <= TEMPLATE_RST;
            cpu_off_reg <= 1'b0;
            wake_pending_reg <= 1'b0;
            wake_dly_reg <= 32'h0;
        end else if (o_sys_reset) begin
            // a device reset outranks any pending wake
            mode_reg <= CPMRC_ACTIVE;
            cpu_off_reg <= 1'b0;
            wake_pending_reg <= 1'b0;
        end else begin
            if (wr_hit(i_bus, ADDR_TEMPLATE)) begin
                template_reg <= i_bus.wdata[7:0];
                cpu_off_reg <= !i_bus.wdata[CPU_TEMPLATE_BIT];
            end
            case (mode_reg)
                CPMRC_ACTIVE, CPMRC_ALT_ACTIVE: begin
                    if (wake_reg) begin
                        mode_reg <= CPMRC_ACTIVE;
                        cpu_off_reg <= 1'b0;
                    end else if (wr_hit(i_bus, ADDR_MODE)) begin
                        // low-power entry trusts firmware to stop the pll first
                        case (i_bus.wdata[1:0])
                            2'h1: mode_reg <= CPMRC_ALT_ACTIVE;
                            2'h2: mode_reg <= CPMRC_SLEEP;
                            2'h3: mode_reg <= CPMRC_HIBERNATE;
                            default: mode_reg <= CPMRC_ACTIVE;
                        endcase
                    end
                end
                CPMRC_SLEEP: begin
                    // wake latency is counted here, the counter keeps running
                    if (wake_reg) begin
                        wake_pending_reg <= 1'b1;
                        wake_dly_reg <= 32'h0;
                    end else if (wake_pending_reg) begin
                        if (wake_dly_reg >= 32'(WAKE_TIME_CYC - 1)) begin
                            mode_reg <= CPMRC_ACTIVE;
                            cpu_off_reg <= 1'b0;
                            wake_pending_reg <= 1'b0;
                        end else begin
                            wake_dly_reg <= wake_dly_reg + 32'h1;
                        end
                    end
                end
                CPMRC_HIBERNATE: begin
                    // only the reset branch above leaves hibernate
                    mode_reg <= CPMRC_HIBERNATE;
                end
                default: mode_reg <= CPMRC_ACTIVE;
            endcase
        end
    end

    // ----------------------------------------
    // watchdog, software and reset sources
    // ----------------------------------------
    assign sw_fire = wr_hit(i_bus, ADDR_RESET) && i_bus.wdata[RST_SW_BIT];
    assign wdog_fire = (mode_reg == CPMRC_ACTIVE) && (wdog_reg >= WDOG_TIMEOUT);

    // counter parks at timeout until the reset clears it

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wdog_reg <= 32'h0;
        end else if (o_sys_reset || mode_reg != CPMRC_ACTIVE
                     || (wr_hit(i_bus, ADDR_WDOG) && i_bus.wdata[15:0] == WDOG_KEY)) begin
            wdog_reg <= 32'h0;
        end else if (!wdog_fire) begin
            wdog_reg <= wdog_reg + 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_src_reg <= RST_SRC_NONE;
            rst_cnt_reg <= 3'h0;
            o_sys_reset <= 1'b1;
        end else begin
            // external pin wins because it alone also ends hibernate
            if (ext_rst) begin
                rst_src_reg <= RST_SRC_EXT;
                rst_cnt_reg <= 3'(RST_PULSE_CYC);
            end else if (mode_reg != CPMRC_HIBERNATE && pf_sync_reg[1]) begin
                rst_src_reg <= RST_SRC_POWER;
                rst_cnt_reg <= 3'(RST_PULSE_CYC);
            end else if (wdog_fire) begin
                rst_src_reg <= RST_SRC_WDOG;
                rst_cnt_reg <= 3'(RST_PULSE_CYC);
            end else if (sw_fire && mode_reg != CPMRC_HIBERNATE) begin
                rst_src_reg <= RST_SRC_SW;
                rst_cnt_reg <= 3'(RST_PULSE_CYC);
            end else if (rst_cnt_reg != 3'h0) begin
                rst_cnt_reg <= rst_cnt_reg - 3'h1;
            end
            // pulse stretch keeps one-cycle sources visible downstream
            o_sys_reset <= ext_rst || (rst_cnt_reg > 3'h1)
                           || (wdog_fire || (sw_fire && mode_reg != CPMRC_HIBERNATE));
        end
    end

    // ----------------------------------------
    // read port and outputs
    // ----------------------------------------
    // read data lasts one cycle, zero otherwise

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg <= 32'h0;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                ADDR_OSC_CTRL: rdata_reg <= {25'h0, clk_reg.slow_sel, clk_reg.dbl_src,
                                             clk_reg.dbl_en, clk_reg.imo_sel};
                ADDR_PLL_CTRL: rdata_reg <= {18'h0, clk_reg.pll_fb_div, clk_reg.pll_in_div,
                                             1'b0, clk_reg.pll_src, clk_reg.pll_en};
                ADDR_PLL_STAT: rdata_reg <= {31'h0, lock_reg};
                ADDR_WAKE_CTRL: rdata_reg <= {30'h0, wake_ctrl_reg};
                ADDR_WAKE_CNT: rdata_reg <= {16'h0, wake_cnt_reg};
                ADDR_TEMPLATE: rdata_reg <= {24'h0, template_reg};
                ADDR_MODE: rdata_reg <= {28'h0, mode_reg};
                ADDR_RESET: rdata_reg <= {29'h0, rst_src_reg};
                ADDR_WDOG: rdata_reg <= wdog_reg;
                default: rdata_reg <= 32'h0;
            endcase
        end else begin
            rdata_reg <= 32'h0;
        end
    end

    // outputs registered once more, one cycle behind state

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_clk_cfg <= '0;
            o_pll_lock <= 1'b0;
            o_clk_gate_en <= 8'h0;
            o_cpu_en <= 1'b0;
            o_mode <= 4'h0;
            o_wake_event <= 1'b0;
            o_wake_irq <= 1'b0;
        end else begin
            o_clk_cfg <= clk_reg;
            o_pll_lock <= lock_reg;
            // low-power modes gate everything; alt active uses its template too
            o_clk_gate_en <= (mode_reg == CPMRC_ACTIVE || mode_reg == CPMRC_ALT_ACTIVE)
                             ? template_reg : 8'h0;
            o_cpu_en <= (mode_reg == CPMRC_ACTIVE) && !cpu_off_reg;
            o_mode <= mode_reg;
            o_wake_event <= wake_reg;
            o_wake_irq <= wake_irq_reg;
        end
    end

    // read data already comes straight from its register
    assign o_rdata = rdata_reg;

endmodule

// ==== tb/cpmrc_monitor.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module cpmrc_monitor
    import cpmrc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire cpmrc_pkg::cpmrc_bus_s i_bus,
    input wire logic i_ext_reset_n,
    input wire logic i_slow_tick_1k,
    input wire logic i_power_fault,
    input wire logic i_debug_halt,
    input wire logic [31:0] o_rdata,
    input wire cpmrc_pkg::cpmrc_clk_s o_clk_cfg,
    input wire logic o_pll_lock,
    input wire logic [7:0] o_clk_gate_en,
    input wire logic o_cpu_en,
    input wire logic [3:0] o_mode,
    input wire logic o_wake_event,
    input wire logic o_wake_irq,
    input wire logic o_sys_reset
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // pin is synced, so allow the two flops plus the output register
    ext_hold_a: assert property (!i_ext_reset_n [*4] |-> o_sys_reset)
        else $error("reset pin low but no device reset");
    boot_mode_a: assert property (!$past(i_rstn) |=> o_mode == 4'b0001)
        else $error("mode not active after boot");
    reset_active_a: assert property (o_sys_reset |-> ##[0:3] o_mode == 4'b0001)
        else $error("device reset left mode non-active");
    irq_with_event_a: assert property (o_wake_irq |-> o_wake_event)
        else $error("wake irq without wake event");
    event_pulse_a: assert property (o_wake_event |=> !o_wake_event)
        else $error("wake event longer than one cycle");
    sleep_gate_a: assert property ((o_mode == 4'b0100) [*2] |->
        o_clk_gate_en == 8'h00 && !o_cpu_en)
        else $error("clocks or cpu on in sleep");
    hib_hold_a: assert property ((o_mode == 4'b1000 && i_ext_reset_n) [*4] |=>
        o_mode == 4'b1000)
        else $error("left hibernate without reset pin");
    pll_restart_a: assert property (i_bus.wr && i_bus.addr == ADDR_PLL_CTRL |->
        ##2 (!o_pll_lock) [*8])
        else $error("lock shown too early after pll write");
    cover property ($rose(o_pll_lock));
    cover property (o_wake_irq);
    cover property (o_mode == 4'b1000);
    cover property ($rose(o_sys_reset));
endmodule

bind cpmrc_top cpmrc_monitor i_mon (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus(i_bus),
    .i_ext_reset_n(i_ext_reset_n), .i_slow_tick_1k(i_slow_tick_1k),
    .i_power_fault(i_power_fault), .i_debug_halt(i_debug_halt), .o_rdata(o_rdata),
    .o_clk_cfg(o_clk_cfg), .o_pll_lock(o_pll_lock), .o_clk_gate_en(o_clk_gate_en),
    .o_cpu_en(o_cpu_en), .o_mode(o_mode), .o_wake_event(o_wake_event),
    .o_wake_irq(o_wake_irq), .o_sys_reset(o_sys_reset));

// ==== tb/test_cpmrc_top.sv ====
`timescale 1ns/1ps
module test_cpmrc_top;
    import cpmrc_pkg::*;
    // ----------------------------------------
    // stimulus and dut
    // ----------------------------------------
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    cpmrc_bus_s i_bus = '0;
    logic i_ext_reset_n = 1'b1;
    logic i_slow_tick_1k = 1'b0;
    logic i_power_fault = 1'b0;
    logic i_debug_halt = 1'b0;
    logic [31:0] o_rdata;
    cpmrc_clk_s o_clk_cfg;
    logic o_pll_lock, o_cpu_en, o_wake_event, o_wake_irq, o_sys_reset;
    logic [7:0] o_clk_gate_en;
    logic [3:0] o_mode;
    int err_count = 0;
    int checks = 0;
    int ev_n = 0;
    int irq_n = 0;
    int rs_n = 0;
    int k, e0, r0;
    logic [31:0] d;
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        ev_n <= ev_n + int'(o_wake_event);
        irq_n <= irq_n + int'(o_wake_irq);
        rs_n <= rs_n + int'(o_sys_reset);
    end
    // short counts keep the run brief
    cpmrc_top #(.WDOG_TIMEOUT(32'd300), .WAKE_INTERVAL(16'd3), .PLL_LOCK_CYCLES(20)) i_dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_bus(i_bus), .i_ext_reset_n(i_ext_reset_n),
        .i_slow_tick_1k(i_slow_tick_1k), .i_power_fault(i_power_fault),
        .i_debug_halt(i_debug_halt), .o_rdata(o_rdata), .o_clk_cfg(o_clk_cfg),
        .o_pll_lock(o_pll_lock), .o_clk_gate_en(o_clk_gate_en), .o_cpu_en(o_cpu_en),
        .o_mode(o_mode), .o_wake_event(o_wake_event), .o_wake_irq(o_wake_irq),
        .o_sys_reset(o_sys_reset));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk);
        i_bus <= '{a, v, 1'b1, 1'b0};
        @(posedge i_clk);
        i_bus.wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge i_clk);
        i_bus.rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    // tick is a level; hold each half long enough for the sync
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge i_clk) i_slow_tick_1k <= 1'b1;
            repeat (4) @(posedge i_clk);
            i_slow_tick_1k <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
    endtask
    task automatic wait_sr(input logic lvl, input int lim);
        for (k = 0; k < lim && o_sys_reset !== lvl; k++) @(posedge i_clk);
        #1 chk(32'(o_sys_reset), 32'(lvl));
    endtask
    task automatic settle();
        repeat (2) @(posedge i_clk);
        #1;
    endtask
    task automatic kick();
        wr(ADDR_WDOG, {16'h0, WDOG_KEY});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_rstn <= 1'b1;
        settle();
        chk(32'(o_mode), 32'h1);
        rchk(ADDR_TEMPLATE, 32'hFF);
        rchk(4'h3, 32'h0);
        rchk(4'hF, 32'h0);
        kick();
        $display("boot done");
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_OSC_CTRL, 32'h58 | 32'(i));
            settle();
            chk(32'(o_clk_cfg.imo_sel), (i > 4) ? 32'h4 : 32'(i));
        end
        chk(32'({o_clk_cfg.dbl_en, o_clk_cfg.dbl_src, o_clk_cfg.slow_sel}), 32'hE);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_PLL_CTRL, 32'h2A31 | (32'(i) << 1));
            settle();
            chk(32'(o_clk_cfg.pll_src), (i == 3) ? 32'h0 : 32'(i));
        end
        chk(32'({o_clk_cfg.pll_in_div, o_clk_cfg.pll_fb_div}), 32'hEA);
        rchk(ADDR_PLL_STAT, 32'h0);
        for (k = 0; k < 40 && o_pll_lock !== 1'b1; k++) @(posedge i_clk);
        chk(32'(k < 22), 32'h1);
        chk(32'(o_pll_lock), 32'h1);
        rchk(ADDR_PLL_STAT, 32'h1);
        wr(ADDR_PLL_CTRL, 32'h0);
        settle();
        chk(32'(o_pll_lock), 32'h0);
        $display("clock done");
        kick();
        wr(ADDR_WAKE_CTRL, 32'h4);
        rchk(ADDR_WAKE_CNT, 32'h0);
        tick(2);
        rchk(ADDR_WAKE_CNT, 32'h2);
        i_debug_halt <= 1'b1;
        settle();
        tick(2);
        rchk(ADDR_WAKE_CNT, 32'h2);
        i_debug_halt <= 1'b0;
        wr(ADDR_TEMPLATE, 32'h5A);
        wr(ADDR_WAKE_CTRL, 32'h7);
        settle();
        chk(32'({o_cpu_en, o_clk_gate_en}), 32'h05A);
        e0 = ev_n;
        tick(2);
        chk(32'(ev_n - e0), 32'h0);
        tick(1);
        chk(32'(ev_n - e0), 32'h1);
        chk(32'(irq_n - e0), 32'h1);
        chk(32'({o_cpu_en, o_mode}), 32'h11);
        $display("wake done");
        kick();
        r0 = rs_n;
        wr(ADDR_MODE, 32'h1);
        settle();
        chk(32'(o_mode), 32'h2);
        repeat (350) @(posedge i_clk);
        chk(32'(rs_n - r0), 32'h0);
        wr(ADDR_MODE, 32'h2);
        settle();
        chk(32'({o_cpu_en, o_clk_gate_en, o_mode}), 32'h4);
        tick(2);
        rchk(ADDR_WAKE_CNT, 32'h5);
        tick(1);
        chk(32'(o_mode), 32'h4);
        for (k = 0; k < 2700 && o_mode !== 4'b0001; k++) @(posedge i_clk);
        chk(32'(k > 2400 && k < 2600), 32'h1);
        $display("modes done");
        kick();
        wr(ADDR_TEMPLATE, 32'hF7);
        wr(ADDR_MODE, 32'h3);
        tick(2);
        rchk(ADDR_WAKE_CNT, 32'h6);
        i_power_fault <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_power_fault <= 1'b0;
        settle();
        chk(32'(o_mode), 32'h8);
        i_ext_reset_n <= 1'b0;
        wait_sr(1'b1, 6);
        repeat (4) @(posedge i_clk);
        i_ext_reset_n <= 1'b1;
        wait_sr(1'b0, 10);
        chk(32'(o_mode), 32'h1);
        rchk(ADDR_TEMPLATE, 32'hF7);
        rchk(ADDR_RESET, 32'(RST_SRC_EXT));
        $display("hibernate done");
        kick();
        repeat (250) @(posedge i_clk);
        kick();
        r0 = rs_n;
        repeat (250) @(posedge i_clk);
        chk(32'(rs_n - r0), 32'h0);
        wait_sr(1'b1, 80);
        wait_sr(1'b0, 10);
        rchk(ADDR_RESET, 32'(RST_SRC_WDOG));
        kick();
        wr(ADDR_RESET, 32'h1);
        wait_sr(1'b1, 8);
        wait_sr(1'b0, 10);
        rchk(ADDR_RESET, 32'(RST_SRC_SW));
        i_power_fault <= 1'b1;
        wait_sr(1'b1, 10);
        i_power_fault <= 1'b0;
        wait_sr(1'b0, 20);
        rchk(ADDR_RESET, 32'(RST_SRC_POWER));
        $display("resets done");
        end_of_test();
    end
endmodule
